/* rtl/lcdcs_core.sv */
// command interpreter of a bit-map lcd driver behind an axi4-lite slave
`include "lcdcs_map.svh"

// Contract
// - column address loads as upper nibble and lower nibble commands
// - each display memory access advances the column by one
// - column stops at 0x83, page never auto-increments
// - status read gives busy, direction, display off, reset in bits 7..4
// - busy reads 1 during operation or reset; host waits for 0
// - direction status reads 1 normal, 0 inverse, opposite of command bit
// - display status reads 0 on, 1 off, opposite of command bit
// - reset status reads 1 during initialization from pin or command
// - data write stores byte at page and column then advances column
// - data read returns byte at page and column then advances column
// - first read after column set returns stale latch content
// - serial mode gives no display memory read data
// - inverse bit selects whether stored 1 or 0 lights pixels
// - whole display on lights all pixels, overrides inverse
// - whole display on while display off enters power save
// - sub-table entry redirects decoding until exit command
// - sixteen units of eight commons, one or two blocks
// - partial on sets partial mode, duty one over eight times units
// - first start 0 with count 16 gives full display at 1/128
// - second start 0 and count 0 gives single block display
// - units stay within 15; memory maps continuously from page 0
// - secondary encodings 0000, 001, 1100, 111 and 01000000
// - sub-table entry 01110000, exit 01110001
module lcdcs_core
  import lcdcs_pkg::*;
#(
  parameter int COLS = 132,
  parameter int PAGES = 24,
  parameter int RESET_CYCLES = `LCDCS_RESET_NS * `LCDCS_CLK_MHZ / 1000
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pixel_invert,
  output logic pixel_force_on,
  output logic power_save,
  output logic partial_mode,
  output logic [7:0] duty_lines
);
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int BUSY_CYC_I = (`LCDCS_BUSY_NS * `LCDCS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] BUSY_CYC = 4'(BUSY_CYC_I < 1 ? 1 : BUSY_CYC_I);
  localparam logic [15:0] INIT_CYC = 16'(RESET_CYCLES);

  logic [7:0] mem_reg [PAGES][COLS];
  logic [7:0] col_reg;
  logic [4:0] page_reg;
  logic disp_on_reg, adc_inv_reg, inverse_reg, whole_on_reg, sub_reg;
  logic serial_reg;
  logic [7:0] read_latch_reg;
  logic read_valid_reg;
  lcdcs_part_t part_reg;
  lcdcs_state_t state_reg;
  logic [15:0] cnt_reg;
  lcdcs_status_t stat;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic aw_have_reg, w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go, rd_go;
  logic bus_cmd, bus_dat, bus_rd;
  logic [7:0] bus_byte;

  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready;
      s_axi_wready <= !w_have_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `LCDCS_ADDR_BUS || aw_addr_reg == `LCDCS_ADDR_CTRL)
          s_axi_bresp <= 2'h0;
        else
          s_axi_bresp <= 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // a bus-register write is one strobe on the lcd port; low byte needed
  assign bus_byte = w_data_reg[7:0];
  assign bus_cmd = wr_go && aw_addr_reg == `LCDCS_ADDR_BUS && w_strb_reg[0]
                   && !w_data_reg[`LCDCS_BUS_SEL_BIT] && state_reg == LCDCS_IDLE;
  assign bus_dat = wr_go && aw_addr_reg == `LCDCS_ADDR_BUS && w_strb_reg[0]
                   && w_data_reg[`LCDCS_BUS_SEL_BIT] && state_reg == LCDCS_IDLE;
  // a read strobe that meets a write strobe in one cycle is refused
  assign bus_rd = rd_go && s_axi_araddr == `LCDCS_ADDR_READ && !wr_go
                  && state_reg == LCDCS_IDLE && !serial_reg;

  assign stat.busy = state_reg != LCDCS_IDLE;
  assign stat.seg_normal = !adc_inv_reg;
  assign stat.disp_off = !disp_on_reg;
  assign stat.in_reset = state_reg == LCDCS_INIT;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == `LCDCS_ADDR_STAT)
          s_axi_rdata <= {24'h0, stat, 4'h0};
        else if (s_axi_araddr == `LCDCS_ADDR_READ)
          s_axi_rdata <= {23'h0, bus_rd, read_latch_reg};
        else if (s_axi_araddr == `LCDCS_ADDR_CTRL)
          s_axi_rdata <= {30'h0, 1'b0, serial_reg};
        else if (s_axi_araddr == `LCDCS_ADDR_PART)
          s_axi_rdata <= {11'h0, partial_mode, part_reg};
        else if (s_axi_araddr == `LCDCS_ADDR_BUS)
          s_axi_rdata <= {16'h0, page_reg[2:0], sub_reg, read_valid_reg,
                          3'h0, col_reg};
        else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // busy and initialization sequencer
  // ---------------------------------------------------------------
  logic sw_rst;
  assign sw_rst = (bus_cmd && !sub_reg && bus_byte == `LCDCS_OP_RESET)
                  || (wr_go && aw_addr_reg == `LCDCS_ADDR_CTRL
                      && w_data_reg[`LCDCS_CTRL_SWRST_BIT]);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= LCDCS_INIT;
      cnt_reg <= INIT_CYC;
    end else if (sw_rst) begin
      // control-register reset is honoured even while busy
      state_reg <= LCDCS_INIT;
      cnt_reg <= INIT_CYC;
    end else begin
      case (state_reg)
        LCDCS_IDLE: begin
          if (bus_cmd || bus_dat || bus_rd) begin
            state_reg <= LCDCS_BUSY;
            cnt_reg <= {12'h0, BUSY_CYC};
          end
        end
        default: begin
          if (cnt_reg <= 16'h1)
            state_reg <= LCDCS_IDLE;
          else
            cnt_reg <= cnt_reg - 16'h1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // address, display state and table select
  // ---------------------------------------------------------------
  logic [7:0] col_inc;
  assign col_inc = (col_reg >= `LCDCS_COL_MAX) ? `LCDCS_COL_MAX
                   : col_reg + 8'h1;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      col_reg <= 8'h00;
      page_reg <= 5'h00;
      disp_on_reg <= 1'b0;
      adc_inv_reg <= 1'b0;
      inverse_reg <= 1'b0;
      whole_on_reg <= 1'b0;
      sub_reg <= 1'b0;
      read_valid_reg <= 1'b0;
      read_latch_reg <= 8'h00;
      serial_reg <= 1'b0;
    end else begin
      if (wr_go && aw_addr_reg == `LCDCS_ADDR_CTRL)
        serial_reg <= w_data_reg[`LCDCS_CTRL_SERIAL_BIT];
      if (sw_rst) begin
        col_reg <= 8'h00;
        page_reg <= 5'h00;
      end else if (bus_cmd && sub_reg) begin
        if (bus_byte == `LCDCS_OP_SUB_EXIT)
          sub_reg <= 1'b0;
      end else if (bus_cmd) begin
        if (bus_byte == `LCDCS_OP_SUB_ENTER)
          sub_reg <= 1'b1;
        else if (bus_byte[7:4] == `LCDCS_NIB_COL_HI) begin
          col_reg <= {bus_byte[3:0], col_reg[3:0]};
          read_valid_reg <= 1'b0;
        end else if (bus_byte[7:4] == `LCDCS_NIB_COL_LO) begin
          col_reg <= {col_reg[7:4], bus_byte[3:0]};
          read_valid_reg <= 1'b0;
        end else if (bus_byte[7:4] == `LCDCS_NIB_PAGE_LO)
          page_reg <= {page_reg[4], bus_byte[3:0]};
        else if (bus_byte[7:4] == `LCDCS_OP_PAGE_HI)
          page_reg <= {bus_byte[0], page_reg[3:0]};
        else if (bus_byte[7:1] == `LCDCS_OP_DISP_ONOFF)
          disp_on_reg <= bus_byte[0];
        else if (bus_byte[7:1] == `LCDCS_OP_INVERSE)
          inverse_reg <= bus_byte[0];
        else if (bus_byte[7:1] == `LCDCS_OP_WHOLE_ON)
          whole_on_reg <= bus_byte[0];
        else if (bus_byte[7:1] == `LCDCS_OP_ADC)
          adc_inv_reg <= bus_byte[0];
      end else if (bus_dat) begin
        col_reg <= col_inc;
      end else if (bus_rd) begin
        read_latch_reg <= mem_reg[page_reg][col_reg];
        read_valid_reg <= 1'b1;
        col_reg <= col_inc;
      end
    end
  end

  // ---------------------------------------------------------------
  // pixel memory, not cleared by any reset
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (bus_dat && int'(page_reg) < PAGES && int'(col_reg) < COLS)
      mem_reg[page_reg][col_reg] <= bus_byte;
  end

  // ---------------------------------------------------------------
  // partial display
  // ---------------------------------------------------------------
  logic [5:0] units_total;
  logic full_sel, single_sel;
  assign full_sel = part_reg.b1_start == 5'h0
                    && part_reg.b1_count == `LCDCS_FULL_UNITS;
  assign single_sel = part_reg.b2_start == 5'h0 && part_reg.b2_count == 5'h0;
  assign units_total = (full_sel || single_sel) ? {1'b0, part_reg.b1_count}
                       : {1'b0, part_reg.b1_count} + {1'b0, part_reg.b2_count};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      part_reg <= '{5'h0, `LCDCS_FULL_UNITS, 5'h0, 5'h0};
      partial_mode <= 1'b0;
      duty_lines <= 8'h80;
    end else if (sw_rst) begin
      partial_mode <= 1'b0;
      duty_lines <= 8'h80;
    end else if (bus_cmd && sub_reg) begin
      if (bus_byte == `LCDCS_OP_PART_ON) begin
        partial_mode <= !full_sel;
        duty_lines <= (units_total >= 6'h10) ? 8'h80
                      : {units_total[4:0], 3'h0};
      end else if (bus_byte[7:4] == `LCDCS_NIB_B1_START)
        part_reg.b1_start <= {1'b0, bus_byte[3:0]};
      else if (bus_byte[7:5] == `LCDCS_TOP_B1_COUNT)
        part_reg.b1_count <= bus_byte[4:0];
      else if (bus_byte[7:4] == `LCDCS_NIB_B2_START)
        part_reg.b2_start <= {1'b0, bus_byte[3:0]};
      else if (bus_byte[7:5] == `LCDCS_TOP_B2_COUNT)
        part_reg.b2_count <= bus_byte[4:0];
    end
  end

  // ---------------------------------------------------------------
  // pixel drive controls
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pixel_invert <= 1'b0;
      pixel_force_on <= 1'b0;
      power_save <= 1'b0;
    end else begin
      pixel_invert <= inverse_reg && !whole_on_reg;
      pixel_force_on <= whole_on_reg;
      power_save <= whole_on_reg && !disp_on_reg;
    end
  end
endmodule // lcdcs_core

/* rtl/lcdcs_map.svh */
// offsets, encodings, reset values and timing in ns and MHz of the lcd command block
`ifndef LCDCS_MAP_SVH
`define LCDCS_MAP_SVH
// axi4-lite byte addresses
`define LCDCS_ADDR_BUS 8'h00
`define LCDCS_ADDR_READ 8'h04
`define LCDCS_ADDR_STAT 8'h08
`define LCDCS_ADDR_CTRL 8'h0c
`define LCDCS_ADDR_PART 8'h10
// bus, read and control register fields
`define LCDCS_BUS_SEL_BIT 8
`define LCDCS_RD_VALID_BIT 8
`define LCDCS_CTRL_SERIAL_BIT 0
`define LCDCS_CTRL_SWRST_BIT 1
// column limit and page address width
`define LCDCS_COL_MAX 8'h83
`define LCDCS_PAGE_W 5
// primary table encodings
`define LCDCS_OP_DISP_ONOFF 7'h57
`define LCDCS_OP_INVERSE 7'h53
`define LCDCS_OP_WHOLE_ON 7'h52
`define LCDCS_OP_ADC 7'h50
`define LCDCS_OP_RESET 8'he2
`define LCDCS_OP_SUB_ENTER 8'h70
`define LCDCS_OP_SUB_EXIT 8'h71
`define LCDCS_NIB_COL_HI 4'h1
`define LCDCS_NIB_COL_LO 4'h0
`define LCDCS_NIB_PAGE_LO 4'hb
`define LCDCS_OP_PAGE_HI 4'h4
// secondary table encodings
`define LCDCS_NIB_B1_START 4'h0
`define LCDCS_TOP_B1_COUNT 3'h1
`define LCDCS_NIB_B2_START 4'hc
`define LCDCS_TOP_B2_COUNT 3'h7
`define LCDCS_OP_PART_ON 8'h40
`define LCDCS_FULL_UNITS 5'h10
// timing
`define LCDCS_BUSY_NS 40
`define LCDCS_RESET_NS 2000
`define LCDCS_CLK_MHZ 250
`endif

/* rtl/lcdcs_pkg.sv */
// types of the lcd command block
package lcdcs_pkg;
  typedef enum logic [1:0] {
    LCDCS_IDLE,
    LCDCS_BUSY,
    LCDCS_INIT
  } lcdcs_state_t;
  typedef struct packed {
    logic [4:0] b1_start;
    logic [4:0] b1_count;
    logic [4:0] b2_start;
    logic [4:0] b2_count;
  } lcdcs_part_t;
  typedef struct packed {
    logic busy;
    logic seg_normal;
    logic disp_off;
    logic in_reset;
  } lcdcs_status_t;
endpackage

/* verif/lcd_column_status_partial_cmd_tb.sv */
// self-checking bench of the lcd command block
module lcd_column_status_partial_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pixel_invert, pixel_force_on, power_save, partial_mode;
  logic [7:0] duty_lines;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] sq[$];
  logic [7:0] dat[3];
  logic [31:0] scratch, m;
  logic [7:0] st_op[4] = '{8'haf, 8'hae, 8'ha1, 8'ha0};
  logic [7:0] px_op[5] = '{8'ha7, 8'ha5, 8'haf, 8'ha4, 8'ha6};
  logic [11:0] px_ex[5] = '{12'h180, 12'ha80, 12'h280, 12'h180, 12'h080};
  int err_total = 0;
  int compares = 0;
  always #2 ref_clk = ~ref_clk;
  lcdcs_axi_if ax (.clk(ref_clk));
  lcdcs_host_model i_host (.bus(ax));
  lcdcs_core #(.RESET_CYCLES(8)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(ax.awaddr), .s_axi_awvalid(ax.awvalid),
    .s_axi_awready(ax.awready), .s_axi_wdata(ax.wdata),
    .s_axi_wstrb(ax.wstrb), .s_axi_wvalid(ax.wvalid),
    .s_axi_wready(ax.wready), .s_axi_bresp(ax.bresp),
    .s_axi_bvalid(ax.bvalid), .s_axi_bready(ax.bready),
    .s_axi_araddr(ax.araddr), .s_axi_arvalid(ax.arvalid),
    .s_axi_arready(ax.arready), .s_axi_rdata(ax.rdata),
    .s_axi_rresp(ax.rresp), .s_axi_rvalid(ax.rvalid),
    .s_axi_rready(ax.rready), .pixel_invert(pixel_invert),
    .pixel_force_on(pixel_force_on), .power_save(power_save),
    .partial_mode(partial_mode), .duty_lines(duty_lines)
  );
  // ----
  // checking
  // ----
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk) begin
    if (ax.bvalid && ax.bready && bq.size() > 0)
      cmp_resp(ax.bresp, bq.pop_front());
    if (ax.rvalid && ax.rready && rq.size() > 0) begin
      cmp_resp(ax.rresp, rq[0][65:64]);
      cmp_data(ax.rdata & rq[0][31:0], rq[0][63:32]);
      void'(rq.pop_front());
    end
  end
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, k,
                     input logic [1:0] r = 2'b00);
    @(negedge ref_clk);
    rq.push_back({r, e, k});
    i_host.rd(a, scratch);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    @(negedge ref_clk);
    bq.push_back(r);
    i_host.wr(a, d);
  endtask
  task automatic cmd(input logic [7:0] b, input logic sel = 1'b0);
    @(negedge ref_clk);
    bq.push_back(2'b00);
    i_host.lcd(b, sel);
  endtask
  task automatic run_sq;
    foreach (sq[k]) cmd(sq[k]);
  endtask
  task automatic lvl(input logic [11:0] e);
    @(negedge ref_clk);
    cmp_data({20'h0, power_save, partial_mode, pixel_force_on, pixel_invert,
              duty_lines}, {20'h0, e});
  endtask
  task automatic report_and_stop;
    $display("compares=%0d errors=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----
  // stimulus
  // ----
  initial begin
    void'($urandom(32'h3b64));
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(8'h08, 32'h90, 32'h9f);
    i_host.poll();
    rdc(8'h08, 32'h00, 32'h9f);
    for (int i = 0; i < 4; i++) begin
      m = (i < 2) ? 32'h20 : 32'h40;
      cmd(st_op[i]);
      rdc(8'h08, st_op[i][0] ? 32'h0 : m, m);
    end
    foreach (px_op[i]) begin
      cmd(px_op[i]);
      lvl(px_ex[i]);
    end
    sq = {8'hb1, 8'h18, 8'h02};
    run_sq();
    rdc(8'h00, 32'h2082, 32'he0ff);
    repeat (3) cmd(8'($urandom), 1'b1);
    rdc(8'h00, 32'h2083, 32'he0ff);
    sq = {8'h11, 8'h00};
    run_sq();
    foreach (dat[i]) begin
      dat[i] = 8'($urandom);
      cmd(dat[i], 1'b1);
    end
    run_sq();
    rdc(8'h04, 32'h100, 32'h100);
    i_host.poll();
    for (int i = 0; i < 2; i++) begin
      rdc(8'h04, {24'h1, dat[i]}, 32'h1ff);
      i_host.poll();
    end
    rdc(8'h00, 32'h2013, 32'he0ff);
    wrc(8'h0c, 32'h1, 2'b00);
    rdc(8'h04, 32'h0, 32'h100);
    rdc(8'h00, 32'h2013, 32'he0ff);
    wrc(8'h0c, 32'h0, 2'b00);
    wrc(8'h08, 32'h0, 2'b10);
    rdc(8'h20, 32'h0, 32'h0, 2'b10);
    wrc(8'h0c, 32'h2, 2'b00);
    rdc(8'h08, 32'h90, 32'h9f);
    i_host.poll();
    sq = {8'h70, 8'h00, 8'h22, 8'hc4, 8'he5, 8'h40};
    run_sq();
    rdc(8'h00, 32'h1000, 32'h1000);
    cmd(8'h71);
    lvl(12'h438);
    rdc(8'h10, 32'h100885, 32'h1fffff);
    sq = {8'h70, 8'h00, 8'h30, 8'h40, 8'h71};
    run_sq();
    lvl(12'h080);
    sq = {8'h70, 8'h03, 8'h24, 8'hc0, 8'he0, 8'h40};
    run_sq();
    lvl(12'h420);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    lvl(12'h080);
    rdc(8'h00, 32'h0, 32'h1000);
    report_and_stop();
  end
  initial begin
    #100us;
    err_total++;
    report_and_stop();
  end
endmodule // lcd_column_status_partial_cmd_tb

/* verif/lcdcs_axi_if.sv */
// axi4-lite wires between the host model and the lcd command block
interface lcdcs_axi_if (
  input logic clk
);
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
endinterface // lcdcs_axi_if

/* verif/lcdcs_core_chk.sv */
// port assertions of the lcd command block
module lcdcs_core_chk (
  input logic ref_clk,
  input logic sys_rst,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic pixel_invert,
  input logic pixel_force_on,
  input logic power_save,
  input logic partial_mode,
  input logic [7:0] duty_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence ar_take(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  chk_stat_low:
    assert property (ar_take(8'h08) |=> s_axi_rvalid && !s_axi_rdata[3:0])
    else $error("status low nibble not zero");
  chk_reset_busy:
    assert property (ar_take(8'h08) |=> !s_axi_rdata[4] || s_axi_rdata[7])
    else $error("reset period shown without busy");
  chk_force_wins:
    assert property (pixel_force_on |-> !pixel_invert)
    else $error("inverse active under whole display on");
  chk_save_force:
    assert property (power_save |-> pixel_force_on)
    else $error("power save without whole display on");
  chk_full_duty:
    assert property (!partial_mode |-> duty_lines == 8'h80)
    else $error("full display not at 128 lines");
  chk_unit_duty:
    assert property (partial_mode |-> !duty_lines[2:0] && duty_lines != 8'h0)
    else $error("partial duty not a whole number of units");
  chk_hw_reset:
    assert property ($past(sys_rst) |-> !partial_mode && !power_save)
    else $error("reset left partial or power save on");
  chk_bad_read:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
      |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
endmodule // lcdcs_core_chk

bind lcdcs_core lcdcs_core_chk i_chk (
  .ref_clk, .sys_rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .pixel_invert,
  .pixel_force_on, .power_save, .partial_mode, .duty_lines
);

/* verif/lcdcs_host_model.sv */
// host model: axi4-lite master that sends lcd strobes and polls busy
module lcdcs_host_model (
  lcdcs_axi_if bus
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    repeat ($urandom_range(2)) @(posedge bus.clk);
    @(posedge bus.clk);
    bus.awaddr <= a;
    bus.wdata <= d;
    bus.awvalid <= 1'b1;
    bus.wvalid <= 1'b1;
    bus.bready <= 1'b1;
    do begin
      @(posedge bus.clk);
      if (bus.awready) bus.awvalid <= 1'b0;
      if (bus.wready) bus.wvalid <= 1'b0;
    end while (!bus.bvalid);
    bus.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge bus.clk);
    bus.araddr <= a;
    bus.arvalid <= 1'b1;
    bus.rready <= 1'b1;
    do begin
      @(posedge bus.clk);
      if (bus.arready) bus.arvalid <= 1'b0;
    end while (!bus.rvalid);
    d = bus.rdata;
    bus.rready <= 1'b0;
  endtask
  // nothing further is sent until busy reads 0
  task automatic poll;
    logic [31:0] s;
    do rd(8'h08, s); while (s[7] !== 1'b0);
  endtask
  // one lcd strobe: byte plus select bit, then busy is waited out
  task automatic lcd(input logic [7:0] b, input logic sel);
    wr(8'h00, {23'h0, sel, b});
    poll();
  endtask
endmodule // lcdcs_host_model
